// file: hdl/ccr_regs.v
// ============================================================
// Control register bank and level engine of a stereo codec
// Assumes a synchronous host port and one frame_tick pulse
// per frame-sync period, plus per-channel zero-cross pulses
// ============================================================
// What this block does
// - Volume bit 7 mutes the DAC channel; common mode kept.
// - Mute entry and exit follow ramp and crossing settings.
// - Active-low mute pin asserts while channel mute bit set.
// - With combine set, both pins assert only when both mute bits are set.
// - Seven-bit level attenuates in 1 dB steps, 0 to 127 dB.
// - Level changes use the selected transition style.
// - Dither bit adds dither to 16-bit ADC output.
// - Format bit: 0 left-justified, 1 I2S, both to 24 bits.
// - ADC control bits 3 and 2 mute ADC channels A and B.
// - High-pass disable freezes and keeps subtracting offset.
// - Wrap bit routes ADC output to the DAC input.
// - Combine bit ANDs the two mute pin controls.
// - Hold bit defers writes; clearing applies all together.
// - Host port enable resets to 0; set means register mode.
// - Low-power bit resets to 1; device stays in low power.
// - Register contents survive the low-power state.
// - Read-only ID: part code high nibble, revision low.
// - Ramp moves 1/8 dB per frame, 1 dB per 8 frames.
// - Crossing wait applies at zero cross or 512-frame timeout.
// - Style 00 immediate, 01 cross, 10 ramp default, 11 both.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "ccr_defines.vh"

module ccr_regs #(
   parameter [3:0] PART_CODE = 4'h5, // Arbitrary value
   parameter [3:0] REV_CODE  = 4'h2  // Arbitrary value
) (
   input  wire       clk,
   input  wire       rstn,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_en,
   input  wire       rd_en,
   output reg  [7:0] rdata,
   input  wire       frame_tick,
   input  wire       zc_a,
   input  wire       zc_b,
   output reg  [9:0] atten_a,
   output reg  [9:0] atten_b,
   output reg        dac_silent_a,
   output reg        dac_silent_b,
   output reg        chan_a_mute_pin_n,
   output reg        chan_b_mute_pin_n,
   output reg        short_word_dither,
   output reg        adc_serial_format,
   output reg        adc_left_silence,
   output reg        adc_right_silence,
   output reg        highpass_off_left,
   output reg        highpass_off_right,
   output reg        adc_to_dac_wrap,
   output reg        host_port_enable,
   output reg        low_power_request
);

   // ==========================================================
   // Functions
   // ==========================================================

   // Target level in eighth-dB units from a volume byte
   function [9:0] ccr_target;
      input [7:0] vol;
      begin
         if (vol[`CCR_B_MUTE]) begin
            ccr_target = `CCR_LVL_MUTE;
         end else begin
            ccr_target = {vol[6:0], 3'b000};
         end
      end
   endfunction

   // One eighth-dB step toward the target
   function [9:0] ccr_step;
      input [9:0] cur;
      input [9:0] tgt;
      begin
         if (cur < tgt) begin
            ccr_step = cur + 10'h001;
         end else if (cur > tgt) begin
            ccr_step = cur - 10'h001;
         end else begin
            ccr_step = cur;
         end
      end
   endfunction

   // Next level for the chosen transition style
   function [9:0] ccr_next;
      input [9:0] cur;
      input [9:0] tgt;
      input [1:0] style;
      input       tick;
      input       fire;
      begin
         case (style)
            `CCR_T_IMM:   ccr_next = tgt;
            `CCR_T_CROSS: ccr_next = fire ? tgt : cur;
            `CCR_T_RAMP:
               ccr_next = tick ? ccr_step(cur, tgt) : cur;
            `CCR_T_BOTH:
               ccr_next = fire ? ccr_step(cur, tgt) : cur;
            default:      ccr_next = cur;
         endcase
      end
   endfunction

   // Frame counter toward the crossing timeout
   function [9:0] ccr_tmo;
      input [9:0] cnt;
      input       idle;
      input       fire;
      input       tick;
      begin
         if (idle || fire) begin
            ccr_tmo = 10'h000;
         end else if (tick) begin
            ccr_tmo = cnt + 10'h001;
         end else begin
            ccr_tmo = cnt;
         end
      end
   endfunction

   // Crossing pulse or expired timeout releases a change
   function ccr_fire;
      input       zc;
      input [9:0] cnt;
      begin
         ccr_fire = zc | (cnt == `CCR_TMO_FRAMES);
      end
   endfunction

   // Channel output is silent once its level reaches mute
   function ccr_silent;
      input [9:0] lvl;
      begin
         ccr_silent = (lvl == `CCR_LVL_MUTE);
      end
   endfunction

   // Staged value while free, applied value while held
   function [7:0] ccr_apply;
      input [7:0] stg;
      input [7:0] cur;
      input       held;
      begin
         if (held) begin
            ccr_apply = cur;
         end else begin
            ccr_apply = stg;
         end
      end
   endfunction

   // Active-low mute pin; combined form needs both requests
   function ccr_pin_n;
      input mine;
      input other;
      input paired;
      begin
         if (paired) begin
            ccr_pin_n = ~(mine & other);
         end else begin
            ccr_pin_n = ~mine;
         end
      end
   endfunction

   // ==========================================================
   // Written (staged) and applied register copies
   // ==========================================================
   reg  [7:0] s_volmix_r;
   reg  [7:0] s_vol_a_r;
   reg  [7:0] s_vol_b_r;
   reg  [7:0] s_adc_r;
   reg  [7:0] s_mode_r;
   reg  [7:0] a_volmix_r;
   reg  [7:0] a_vol_a_r;
   reg  [7:0] a_vol_b_r;
   reg  [7:0] a_adc_r;
   reg  [7:0] a_mode_r;
   reg  [9:0] tmo_a_r;
   reg  [9:0] tmo_b_r;
   reg  [9:0] lvl_a_nxt;
   reg  [9:0] lvl_b_nxt;
   reg  [7:0] rdata_nxt;

   wire [1:0] style;
   wire [9:0] tgt_a;
   wire [9:0] tgt_b;
   wire       fire_a;
   wire       fire_b;
   wire       hold;
   wire       mreq_a;
   wire       mreq_b;
   wire       comb;

   // Host writes, reserved bits masked off
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_volmix_r <= `CCR_R_VOLMIX;
         s_vol_a_r  <= `CCR_R_VOL;
         s_vol_b_r  <= `CCR_R_VOL;
         s_adc_r    <= `CCR_R_ADC;
         s_mode_r   <= `CCR_R_MODE;
      end else if (wr_en) begin
         // No path clears these in low power
         case (addr)
            `CCR_A_VOLMIX:
               s_volmix_r <= wdata & `CCR_M_VOLMIX;
            `CCR_A_VOL_A:  s_vol_a_r <= wdata & `CCR_M_VOL;
            `CCR_A_VOL_B:  s_vol_b_r <= wdata & `CCR_M_VOL;
            `CCR_A_ADC:    s_adc_r <= wdata & `CCR_M_ADC;
            `CCR_A_MODE:   s_mode_r <= wdata & `CCR_M_MODE;
            default:       s_mode_r <= s_mode_r;
         endcase
      end
   end

   // Hold follows the written copy so it can always be cleared
   assign hold = s_mode_r[`CCR_B_HOLD];

   // Copy staged values into effect unless held
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_volmix_r <= `CCR_R_VOLMIX;
         a_vol_a_r  <= `CCR_R_VOL;
         a_vol_b_r  <= `CCR_R_VOL;
         a_adc_r    <= `CCR_R_ADC;
         a_mode_r   <= `CCR_R_MODE;
      end else begin
         a_volmix_r <= ccr_apply(s_volmix_r, a_volmix_r, hold);
         a_vol_a_r  <= ccr_apply(s_vol_a_r, a_vol_a_r, hold);
         a_vol_b_r  <= ccr_apply(s_vol_b_r, a_vol_b_r, hold);
         a_adc_r    <= ccr_apply(s_adc_r, a_adc_r, hold);
         a_mode_r   <= ccr_apply(s_mode_r, a_mode_r, hold);
      end
   end

   // ==========================================================
   // Register read port
   // ==========================================================

   // Read data, one cycle after the strobe; unmapped read zero
   always @* begin
      rdata_nxt = 8'h00;
      if (rd_en) begin
         case (addr)
            `CCR_A_VOLMIX: rdata_nxt = s_volmix_r;
            `CCR_A_VOL_A:  rdata_nxt = s_vol_a_r;
            `CCR_A_VOL_B:  rdata_nxt = s_vol_b_r;
            `CCR_A_ADC:    rdata_nxt = s_adc_r;
            `CCR_A_MODE:   rdata_nxt = s_mode_r;
            `CCR_A_ID:
               rdata_nxt = {PART_CODE, REV_CODE};
            default:       rdata_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   // ==========================================================
   // Level engine, one per DAC channel
   // ==========================================================
   assign style = {a_volmix_r[`CCR_B_SOFT],
                   a_volmix_r[`CCR_B_CROSS]};
   assign tgt_a = ccr_target(a_vol_a_r);
   assign tgt_b = ccr_target(a_vol_b_r);

   // Zero crossing or timeout releases a pending change
   assign fire_a = ccr_fire(zc_a, tmo_a_r);
   assign fire_b = ccr_fire(zc_b, tmo_b_r);

   // Next levels; mute uses the same path as volume
   always @* begin
      lvl_a_nxt = ccr_next(atten_a, tgt_a, style,
                           frame_tick, fire_a);
      lvl_b_nxt = ccr_next(atten_b, tgt_b, style,
                           frame_tick, fire_b);
   end

   // Levels and silence flags
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         atten_a      <= `CCR_LVL_ZERO;
         atten_b      <= `CCR_LVL_ZERO;
         dac_silent_a <= 1'b0;
         dac_silent_b <= 1'b0;
      end else begin
         atten_a      <= lvl_a_nxt;
         atten_b      <= lvl_b_nxt;
         // Silence only the signal; common mode stays
         dac_silent_a <= ccr_silent(lvl_a_nxt);
         dac_silent_b <= ccr_silent(lvl_b_nxt);
      end
   end

   // ==========================================================
   // Crossing timeout counters
   // ==========================================================

   // Frame ticks counted while a change is still pending
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tmo_a_r <= 10'h000;
         tmo_b_r <= 10'h000;
      end else begin
         tmo_a_r <= ccr_tmo(tmo_a_r, atten_a == tgt_a,
                            fire_a, frame_tick);
         tmo_b_r <= ccr_tmo(tmo_b_r, atten_b == tgt_b,
                            fire_b, frame_tick);
      end
   end

   // ==========================================================
   // Mute pins and converter controls
   // ==========================================================
   assign mreq_a = a_vol_a_r[`CCR_B_MUTE];
   assign mreq_b = a_vol_b_r[`CCR_B_MUTE];
   assign comb   = a_mode_r[`CCR_B_COMB];

   // Active-low pins; combined mode uses the AND form
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_a_mute_pin_n <= 1'b1;
         chan_b_mute_pin_n <= 1'b1;
      end else begin
         chan_a_mute_pin_n <= ccr_pin_n(mreq_a, mreq_b, comb);
         chan_b_mute_pin_n <= ccr_pin_n(mreq_b, mreq_a, comb);
      end
   end

   // Applied control bits out to the converters
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         short_word_dither  <= 1'b0;
         adc_serial_format  <= 1'b0;
         adc_left_silence   <= 1'b0;
         adc_right_silence  <= 1'b0;
         highpass_off_left  <= 1'b0;
         highpass_off_right <= 1'b0;
      end else begin
         short_word_dither  <= a_adc_r[`CCR_B_DITH];
         adc_serial_format  <= a_adc_r[`CCR_B_FMT];
         adc_left_silence   <= a_adc_r[`CCR_B_AMUTE_L];
         adc_right_silence  <= a_adc_r[`CCR_B_AMUTE_R];
         highpass_off_left  <= a_adc_r[`CCR_B_HPF_L];
         highpass_off_right <= a_adc_r[`CCR_B_HPF_R];
      end
   end

   // Applied mode bits out to the device controls
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         adc_to_dac_wrap    <= 1'b0;
         host_port_enable   <= 1'b0;
         low_power_request  <= 1'b1;
      end else begin
         adc_to_dac_wrap    <= a_mode_r[`CCR_B_WRAP];
         host_port_enable   <= a_mode_r[`CCR_B_HOST];
         low_power_request  <= a_mode_r[`CCR_B_LOWP];
      end
   end

endmodule // ccr_regs

// file: include/ccr_defines.vh
// ============================================================
// Codec control register bank: offsets, fields, reset values
// Assumes inclusion by bare name from the design files
// ============================================================
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// Register offsets
`define CCR_A_VOLMIX   8'h03
`define CCR_A_VOL_A    8'h04
`define CCR_A_VOL_B    8'h05
`define CCR_A_ADC      8'h06
`define CCR_A_MODE     8'h07
`define CCR_A_ID       8'h08

// Reset values
`define CCR_R_VOLMIX   8'h20
`define CCR_R_VOL      8'h00
`define CCR_R_ADC      8'h00
`define CCR_R_MODE     8'h01

// Writable bit masks, reserved bits read as zero
`define CCR_M_VOLMIX   8'h30
`define CCR_M_VOL      8'hFF
`define CCR_M_ADC      8'h3F
`define CCR_M_MODE     8'h1F

// Field positions
`define CCR_B_SOFT     5
`define CCR_B_CROSS    4
`define CCR_B_MUTE     7
`define CCR_B_DITH     5
`define CCR_B_FMT      4
`define CCR_B_AMUTE_L  3
`define CCR_B_AMUTE_R  2
`define CCR_B_HPF_L    1
`define CCR_B_HPF_R    0
`define CCR_B_WRAP     4
`define CCR_B_COMB     3
`define CCR_B_HOLD     2
`define CCR_B_HOST     1
`define CCR_B_LOWP     0

// Transition styles {gradual_ramp, crossing_wait}
`define CCR_T_IMM      2'b00
`define CCR_T_CROSS    2'b01
`define CCR_T_RAMP     2'b10
`define CCR_T_BOTH     2'b11

// Level in eighth-dB units; mute sits above max attenuation
`define CCR_LVL_MUTE   10'h3FF
`define CCR_LVL_ZERO   10'h000
// Frames without a zero crossing before forcing a change
`define CCR_TMO_FRAMES 10'h200

`endif

// file: verification/ccr_asserts.sv
// ==========================================================
// Checker for the codec control register bank
// Assumes binding onto ccr_regs, one clock domain
`timescale 1ns/1ps
module ccr_asserts #(
   parameter [3:0] PART_CODE = 4'h5,
   parameter [3:0] REV_CODE  = 4'h2
) (
   input wire       clk,
   input wire       rstn,
   input wire [7:0] addr,
   input wire       wr_en,
   input wire       rd_en,
   input wire [7:0] rdata,
   input wire       frame_tick,
   input wire       zc_a,
   input wire       zc_b,
   input wire [9:0] atten_a,
   input wire [9:0] atten_b,
   input wire       dac_silent_a,
   input wire       dac_silent_b,
   input wire       short_word_dither,
   input wire       adc_serial_format,
   input wire       adc_left_silence,
   input wire       adc_right_silence,
   input wire       highpass_off_left,
   input wire       highpass_off_right,
   input wire       adc_to_dac_wrap,
   input wire       host_port_enable,
   input wire       low_power_request
);
   // Applied control bits as one vector
   wire [8:0] ctrl = {short_word_dither, adc_serial_format,
      adc_left_silence, adc_right_silence, highpass_off_left,
      highpass_off_right, adc_to_dac_wrap, host_port_enable,
      low_power_request};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data outside its slot");
   a_id_value: assert property ($past(rd_en) && $past(addr) == 8'h08
      |-> rdata == {PART_CODE, REV_CODE}) else $error("bad id");
   a_adc_resv: assert property ($past(rd_en) && $past(addr) == 8'h06
      |-> rdata[7:6] == 2'h0) else $error("reserved bits set");
   a_ctrl_cause: assert property ($changed(ctrl) |-> $past(wr_en, 3))
      else $error("control changed without a write");
   a_atten_a_cause: assert property ($changed(atten_a) |-> $past(zc_a)
      || $past(frame_tick) || $past(frame_tick, 2) || $past(wr_en, 3))
      else $error("level a moved without cause");
   a_atten_b_cause: assert property ($changed(atten_b) |-> $past(zc_b)
      || $past(frame_tick) || $past(frame_tick, 2) || $past(wr_en, 3))
      else $error("level b moved without cause");
   a_silent_a: assert property ($stable(atten_a)
      |-> dac_silent_a == (atten_a == 10'h3FF)) else $error("silent a");
   a_silent_b: assert property ($stable(atten_b)
      |-> dac_silent_b == (atten_b == 10'h3FF)) else $error("silent b");
endmodule // ccr_asserts

bind ccr_regs ccr_asserts #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE))
   u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .frame_tick(frame_tick),
      .zc_a(zc_a), .zc_b(zc_b), .atten_a(atten_a), .atten_b(atten_b),
      .dac_silent_a(dac_silent_a), .dac_silent_b(dac_silent_b),
      .short_word_dither(short_word_dither),
      .adc_serial_format(adc_serial_format),
      .adc_left_silence(adc_left_silence),
      .adc_right_silence(adc_right_silence),
      .highpass_off_left(highpass_off_left),
      .highpass_off_right(highpass_off_right),
      .adc_to_dac_wrap(adc_to_dac_wrap),
      .host_port_enable(host_port_enable),
      .low_power_request(low_power_request));

// file: verification/ccr_host.sv
// ==========================================================
// Host model driving the register port as bus master
// Assumes read data one cycle after the read strobe
`timescale 1ns/1ps
module ccr_host (
   input  wire       clk,
   input  wire [7:0] rdata,
   output reg  [7:0] addr  = 8'h00,
   output reg  [7:0] wdata = 8'h00,
   output reg        wr_en = 1'b0,
   output reg        rd_en = 1'b0
);
   // One-cycle write, bus inverted once released
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr  <= a;
         wdata <= d;
         wr_en <= 1'b1;
         @(posedge clk);
         wr_en <= 1'b0;
         addr  <= ~a;
         wdata <= ~d;
      end
   endtask
   // One-cycle read, data taken in the following slot
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk);
         addr  <= a;
         rd_en <= 1'b1;
         @(posedge clk);
         rd_en <= 1'b0;
         addr  <= ~a;
         #1;
         d = rdata;
      end
   endtask
endmodule // ccr_host

// file: verification/codec_control_registers_test.sv
// ==========================================================
// Self-checking bench for the codec control register bank
// Assumes ccr_regs, the host model and the bound checker
`timescale 1ns/1ps
module codec_control_registers_test;
   localparam [3:0] PART = 4'hA; // Arbitrary value
   localparam [3:0] REV  = 4'h3; // Arbitrary value
   reg        clk = 1'b0;
   reg        rstn = 1'b0;
   reg        frame_tick = 1'b0;
   reg        zc_a = 1'b0;
   reg        zc_b = 1'b0;
   wire [7:0] addr, wdata, rdata;
   wire       wr_en, rd_en;
   wire [9:0] atten_a, atten_b;
   wire [8:0] ctrl;
   wire [3:0] dac;
   reg  [7:0] d;
   integer    fails, checks_done, cyc, i;
   // Clock and hang limit
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         final_report;
      end
   end
   ccr_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en));
   ccr_regs #(.PART_CODE(PART), .REV_CODE(REV)) uut (.clk(clk),
      .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .frame_tick(frame_tick),
      .zc_a(zc_a), .zc_b(zc_b), .atten_a(atten_a), .atten_b(atten_b),
      .dac_silent_a(dac[3]), .dac_silent_b(dac[2]),
      .chan_a_mute_pin_n(dac[1]), .chan_b_mute_pin_n(dac[0]),
      .short_word_dither(ctrl[8]), .adc_serial_format(ctrl[7]),
      .adc_left_silence(ctrl[6]), .adc_right_silence(ctrl[5]),
      .highpass_off_left(ctrl[4]), .highpass_off_right(ctrl[3]),
      .adc_to_dac_wrap(ctrl[2]), .host_port_enable(ctrl[1]),
      .low_power_request(ctrl[0]));
   // Shared helpers
   task chk(input [9:0] seen, input [9:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task settle;
      begin
         repeat (4) @(posedge clk);
         #1;
      end
   endtask
   task pulse(input [2:0] m);
      begin
         @(posedge clk);
         {zc_b, zc_a, frame_tick} <= m;
         @(posedge clk);
         {zc_b, zc_a, frame_tick} <= 3'h0;
      end
   endtask
   task rdchk(input [7:0] a, input [7:0] e);
      begin
         host.rd(a, d);
         chk(d, e);
      end
   endtask
   // Reset values, identity, unmapped place
   task t_reset;
      begin
         chk(ctrl, 9'h001);
         chk(dac, 4'h3);
         rdchk(8'h03, 8'h20);
         rdchk(8'h07, 8'h01);
         host.wr(8'h08, 8'hFF);
         rdchk(8'h08, {PART, REV});
         rdchk(8'h40, 8'h00);
      end
   endtask
   // Each ADC bit alone, reserved bits set, then mode bits
   task t_adc;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            host.wr(8'h06, 8'hC0 | (8'h01 << i));
            settle;
            chk(ctrl[8:3], 6'h01 << i);
            rdchk(8'h06, 8'h01 << i);
         end
         host.wr(8'h07, 8'hF2);
         settle;
         chk(ctrl[2:0], 3'h6);
         rdchk(8'h07, 8'h12);
      end
   endtask
   // Deferred ADC write lands when hold clears
   task t_hold;
      begin
         host.wr(8'h07, 8'h06);
         host.wr(8'h06, 8'h3F);
         settle;
         chk(ctrl[8:3], 6'h20);
         rdchk(8'h06, 8'h3F);
         host.wr(8'h07, 8'h02);
         settle;
         chk(ctrl[8:3], 6'h3F);
      end
   endtask
   // Immediate style levels, mute and pin joining
   task t_mute;
      begin
         host.wr(8'h03, 8'h00);
         host.wr(8'h04, 8'h14);
         settle;
         chk(atten_a, 10'h0A0);
         host.wr(8'h04, 8'h7F);
         settle;
         chk(atten_a, 10'h3F8);
         host.wr(8'h04, 8'h80);
         settle;
         chk(atten_a, 10'h3FF);
         chk(dac, 4'h9);
         rdchk(8'h04, 8'h80);
         host.wr(8'h07, 8'h0A);
         settle;
         chk(dac, 4'hB);
         host.wr(8'h05, 8'h80);
         settle;
         chk(dac, 4'hC);
         rdchk(8'h05, 8'h80);
         host.wr(8'h04, 8'h00);
         host.wr(8'h05, 8'h00);
         settle;
         chk(dac, 4'h3);
      end
   endtask
   // Ramp style: one eighth dB per frame until target
   task t_ramp;
      begin
         host.wr(8'h03, 8'h20);
         host.wr(8'h04, 8'h01);
         settle;
         for (i = 1; i <= 9; i = i + 1) begin
            pulse(3'h1);
            settle;
            chk(atten_a, (i > 8) ? 10'h008 : i[9:0]);
         end
      end
   endtask
   // Crossing style: jump on crossing or after 512 frames
   task t_cross;
      begin
         host.wr(8'h03, 8'h10);
         host.wr(8'h05, 8'h02);
         settle;
         chk(atten_b, 10'h000);
         pulse(3'h4);
         settle;
         chk(atten_b, 10'h010);
         host.wr(8'h05, 8'h04);
         for (i = 0; i < 511; i = i + 1)
            pulse(3'h1);
         settle;
         chk(atten_b, 10'h010);
         pulse(3'h1);
         settle;
         chk(atten_b, 10'h020);
      end
   endtask
   // Ramp at crossings: one step per crossing only
   task t_both;
      begin
         host.wr(8'h03, 8'h30);
         host.wr(8'h04, 8'h02);
         settle;
         pulse(3'h1);
         settle;
         chk(atten_a, 10'h008);
         pulse(3'h2);
         settle;
         chk(atten_a, 10'h009);
      end
   endtask
   // Verdict and end of run
   task final_report;
      begin
         $display("checks %0d, mismatches %0d", checks_done, fails);
         if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      fails = 0;
      checks_done = 0;
      cyc = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_adc;
      t_hold;
      t_mute;
      t_ramp;
      t_cross;
      t_both;
      final_report;
   end
endmodule // codec_control_registers_test
